// file: cg_host_model.sv
// serial host model: clock and open-drain data
`timescale 1ns/1ps
module cg_host_model (
	output logic o_scl = 1,
	output logic o_sda = 1,
	input wire logic i_sda
);
	task automatic st; o_sda = 1; #12 o_scl = 1; #12 o_sda = 0; #12 o_scl = 0; #12; endtask
	task automatic sp; o_sda = 0; #12 o_scl = 1; #12 o_sda = 1; #24; endtask
	task automatic bit_io(logic b, output logic r);
		o_sda = b; #12 o_scl = 1; #12 r = i_sda; #12 o_scl = 0; #12;
	endtask
	task automatic xfer(logic [7:0] d, logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(a, k);
	endtask
endmodule

// file: cg_pin_sync.sv
// two-flop synchroniser with edge detection for the serial clock and data pins
`timescale 1ns/1ps
module cg_pin_sync (
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_rst_n,
	input  wire cg_regs_pkg::bus_pins_t i_pins,
	output cg_regs_pkg::bus_pins_t      o_pins,
	output logic                        o_scl_rise,
	output logic                        o_scl_fall,
	output logic                        o_start,
	output logic                        o_stop
);
	cg_regs_pkg::bus_pins_t meta_q, meta_d;
	cg_regs_pkg::bus_pins_t sync_q, sync_d;
	cg_regs_pkg::bus_pins_t prev_q, prev_d;

	always_comb begin
		meta_d = i_pins;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	// idle bus is high on both lines, so reset to high to avoid false edges
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= '{scl: 1'b1, sda: 1'b1};
			sync_q <= '{scl: 1'b1, sda: 1'b1};
			prev_q <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign o_pins     = sync_q;
	assign o_scl_rise = sync_q.scl & ~prev_q.scl;
	assign o_scl_fall = ~sync_q.scl & prev_q.scl;
	assign o_start    = sync_q.scl & prev_q.scl & prev_q.sda & ~sync_q.sda;
	assign o_stop     = sync_q.scl & prev_q.scl & ~prev_q.sda & sync_q.sda;
endmodule

// file: cg_regs_pkg.sv
// package with register map, field positions and serial protocol constants
package cg_regs_pkg;

	// ==========================================================
	// slave addresses (8-bit form, direction bit included)
	localparam logic [7:0] ADDR_WR = 8'hD2;
	localparam logic [7:0] ADDR_RD = 8'hD3;

	// ==========================================================
	// register indices
	localparam logic [7:0] IDX_FREQ_SEL_READBACK = 8'h00;
	localparam logic [7:0] IDX_SPREAD_OUT_BEHAV  = 8'h01;
	localparam logic [7:0] IDX_STOP_PD_DRIVE     = 8'h02;
	localparam logic [7:0] NUM_REGS              = 8'h03;

	// ==========================================================
	// field positions
	localparam int BIT_FREQ_SEL_LOW     = 0;
	localparam int BIT_FREQ_SEL_HIGH    = 1;
	localparam int BIT_SREF_STOPPABLE   = 7;
	localparam int BIT_SREF_EN          = 6;
	localparam int BIT_HOST_PAIR2_EN    = 2;
	localparam int BIT_HOST_PAIR1_EN    = 1;
	localparam int BIT_HOST_PAIR0_EN    = 0;
	localparam int BIT_SREF_PD_DRIVE    = 7;
	localparam int BIT_SREF_STOP_DRIVE  = 6;
	localparam int BIT_PAIR2_PD_DRIVE   = 5;
	localparam int BIT_PAIR1_PD_DRIVE   = 4;
	localparam int BIT_PAIR0_PD_DRIVE   = 3;

	// ==========================================================
	// power-on values and writable masks
	localparam logic [7:0] RST_SPREAD_OUT_BEHAV = 8'h47;
	localparam logic [7:0] RST_STOP_PD_DRIVE    = 8'h00;
	localparam logic [7:0] WMASK_SPREAD_OUT     = 8'hC7;
	localparam logic [7:0] WMASK_STOP_PD        = 8'hF8;

	// ==========================================================
	// bit counter limits
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK  = 4'h8;

	// ==========================================================
	// positions of the slow side inputs inside their synchroniser vector
	localparam int SIDE_FS_LOW  = 0;
	localparam int SIDE_FS_HIGH = 1;
	localparam int SIDE_STOP_N  = 2;
	localparam int SIDE_PD_N    = 3;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_INDEX = 3'b010,
		ST_COUNT = 3'b011,
		ST_WDATA = 3'b100,
		ST_RDATA = 3'b101,
		ST_SKIP  = 3'b110
	} xfer_state_t;

	// serial pin samples after synchronising
	typedef struct packed {
		logic scl;
		logic sda;
	} bus_pins_t;

	// output behaviour decoded from the registers
	typedef struct packed {
		logic [2:0] host_pair_en;
		logic [2:0] host_pair_pd_tristate;
		logic       serial_ref_en;
		logic       serial_ref_stoppable;
		logic       serial_ref_stop_drive_sel;
		logic       serial_ref_powerdown_drive_sel;
	} out_ctrl_t;

endpackage

// file: cg_serial_regs.sv
// serial control port and first three configuration registers of the clock generator
// What this block does
// - data bytes land at consecutive indices
// - acknowledge address, index, count, each data byte within count
// - read address D3 is acknowledged
// - read returns count then consecutive registers
// - stop-drive bit tristates serial reference pair
// - free-running output ignores every stop request
`timescale 1ns/1ps
module cg_serial_regs (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_oe,
	output logic            o_sda_out,
	input  wire logic       i_freq_sel_low,
	input  wire logic       i_freq_sel_high,
	input  wire logic       i_stop_n,
	input  wire logic       i_power_down_n,
	output logic [2:0]      o_host_pair_en,
	output logic [2:0]      o_host_pair_pd_tristate,
	output logic            o_serial_ref_en,
	output logic            o_serial_ref_stop_req,
	output logic            o_serial_ref_tristate
);

	// ==========================================================
	// serial pins: synchronised and edge-detected in the helper
	cg_regs_pkg::bus_pins_t pins_raw;
	cg_regs_pkg::bus_pins_t pins;
	logic                   scl_rise;
	logic                   scl_fall;
	logic                   start_seen;
	logic                   stop_seen;

	assign pins_raw = {i_scl, i_sda};

	cg_pin_sync u_cg_pin_sync (
		.i_clk_sys  (i_clk_sys),
		.i_rst_n    (i_rst_n),
		.i_pins     (pins_raw),
		.o_pins     (pins),
		.o_scl_rise (scl_rise),
		.o_scl_fall (scl_fall),
		.o_start    (start_seen),
		.o_stop     (stop_seen)
	);

	// ==========================================================
	// slow side inputs: two flops each before any logic reads them
	logic [3:0] side_meta_q, side_meta_d;
	logic [3:0] side_sync_q, side_sync_d;
	logic       fs_low;
	logic       fs_high;
	logic       stop_active;
	logic       pd_active;

	always_comb begin
		side_meta_d = {i_power_down_n, i_stop_n, i_freq_sel_high, i_freq_sel_low};
		side_sync_d = side_meta_q;
	end

	// stop and power-down idle high, so those flops reset high
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			side_meta_q <= {1'b1, 1'b1, 1'b0, 1'b0};
			side_sync_q <= {1'b1, 1'b1, 1'b0, 1'b0};
		end else begin
			side_meta_q <= side_meta_d;
			side_sync_q <= side_sync_d;
		end
	end

	assign fs_low      = side_sync_q[cg_regs_pkg::SIDE_FS_LOW];
	assign fs_high     = side_sync_q[cg_regs_pkg::SIDE_FS_HIGH];
	assign stop_active = ~side_sync_q[cg_regs_pkg::SIDE_STOP_N];
	assign pd_active   = ~side_sync_q[cg_regs_pkg::SIDE_PD_N];

	// ==========================================================
	// helpers
	function automatic logic [7:0] merge_bits(input logic [7:0] old_val,
			input logic [7:0] new_val, input logic [7:0] mask);
		return (old_val & ~mask) | (new_val & mask);
	endfunction

	function automatic logic [7:0] read_reg(input logic [7:0] idx, input logic [7:0] r0,
			input logic [7:0] r1, input logic [7:0] r2);
		logic [7:0] val;
		val = 8'h00;
		case (idx)
			cg_regs_pkg::IDX_FREQ_SEL_READBACK: val = r0;
			cg_regs_pkg::IDX_SPREAD_OUT_BEHAV:  val = r1;
			cg_regs_pkg::IDX_STOP_PD_DRIVE:     val = r2;
			default:                            val = 8'h00;
		endcase
		return val;
	endfunction

	// indices past the last register report nothing left to send
	function automatic logic [7:0] bytes_left(input logic [7:0] idx);
		return (idx < cg_regs_pkg::NUM_REGS) ? (cg_regs_pkg::NUM_REGS - idx) : 8'h00;
	endfunction

	// ==========================================================
	// transfer engine and register state
	cg_regs_pkg::xfer_state_t state_q, state_d;
	logic [3:0]               bit_q, bit_d;
	logic                     ack_slot_q, ack_slot_d;
	logic                     host_nack_q, host_nack_d;
	logic                     count_sent_q, count_sent_d;
	logic [7:0]               shift_q, shift_d;
	logic [7:0]               index_q, index_d;
	logic [7:0]               count_q, count_d;
	logic                     sda_oe_q, sda_oe_d;
	logic                     sda_out_q, sda_out_d;
	logic [7:0]               reg1_q, reg1_d;
	logic [7:0]               reg2_q, reg2_d;
	logic [7:0]               reg0_val;
	logic                     receiving;
	logic                     byte_ok;

	always_comb begin
		reg0_val = 8'h00;
		reg0_val[cg_regs_pkg::BIT_FREQ_SEL_LOW]  = fs_low;
		reg0_val[cg_regs_pkg::BIT_FREQ_SEL_HIGH] = fs_high;
		receiving = (state_q == cg_regs_pkg::ST_ADDR) || (state_q == cg_regs_pkg::ST_INDEX)
			|| (state_q == cg_regs_pkg::ST_COUNT) || (state_q == cg_regs_pkg::ST_WDATA);
		byte_ok = 1'b0;
		case (state_q)
			cg_regs_pkg::ST_ADDR:  byte_ok = (shift_q == cg_regs_pkg::ADDR_WR)
				|| (shift_q == cg_regs_pkg::ADDR_RD);
			cg_regs_pkg::ST_INDEX: byte_ok = 1'b1;
			cg_regs_pkg::ST_COUNT: byte_ok = 1'b1;
			cg_regs_pkg::ST_WDATA: byte_ok = (count_q != 8'h00);
			default:               byte_ok = 1'b0;
		endcase
	end

	always_comb begin
		state_d      = state_q;
		bit_d        = bit_q;
		ack_slot_d   = ack_slot_q;
		host_nack_d  = host_nack_q;
		count_sent_d = count_sent_q;
		shift_d      = shift_q;
		index_d      = index_q;
		count_d      = count_q;
		sda_oe_d     = sda_oe_q;
		sda_out_d    = sda_out_q;
		reg1_d       = reg1_q;
		reg2_d       = reg2_q;
		if (stop_seen) begin
			state_d    = cg_regs_pkg::ST_IDLE;
			sda_oe_d   = 1'b0;
			ack_slot_d = 1'b0;
		end else if (start_seen) begin
			state_d    = cg_regs_pkg::ST_ADDR;
			bit_d      = '0;
			ack_slot_d = 1'b0;
			sda_oe_d   = 1'b0;
		end else if (state_q == cg_regs_pkg::ST_RDATA) begin
			if (scl_rise) begin
				if (bit_q == cg_regs_pkg::BIT_ACK) begin
					host_nack_d = pins.sda;
				end else begin
					bit_d = bit_q + 4'h1;
				end
			end else if (scl_fall) begin
				if (ack_slot_q) begin
					ack_slot_d = 1'b0;
					if (host_nack_q) begin
						state_d = cg_regs_pkg::ST_SKIP;
					end else begin
						// first data byte is index n itself, later ones step up
						if (count_sent_q) begin
							count_sent_d = 1'b0;
							shift_d      = read_reg(index_q, reg0_val, reg1_q, reg2_q);
						end else begin
							index_d = index_q + 8'h01;
							shift_d = read_reg(index_q + 8'h01, reg0_val, reg1_q, reg2_q);
						end
						sda_oe_d  = 1'b1;
						sda_out_d = shift_d[7];
						bit_d     = '0;
					end
				end else if (bit_q == cg_regs_pkg::BIT_ACK) begin
					// host owns the line for its acknowledge
					sda_oe_d   = 1'b0;
					ack_slot_d = 1'b1;
				end else if (bit_q != '0) begin
					shift_d   = {shift_q[6:0], 1'b0};
					sda_out_d = shift_q[6];
				end
			end
		end else if (receiving) begin
			if (scl_rise && (bit_q != cg_regs_pkg::BIT_ACK)) begin
				shift_d = {shift_q[6:0], pins.sda};
				bit_d   = bit_q + 4'h1;
			end else if (scl_fall && ack_slot_q) begin
				// acknowledge slot over: free the line, then act on the byte
				sda_oe_d   = 1'b0;
				ack_slot_d = 1'b0;
				bit_d      = '0;
				case (state_q)
					cg_regs_pkg::ST_ADDR: begin
						if (shift_q == cg_regs_pkg::ADDR_RD) begin
							state_d      = cg_regs_pkg::ST_RDATA;
							count_sent_d = 1'b1;
							host_nack_d  = 1'b0;
							shift_d      = bytes_left(index_q);
							sda_oe_d     = 1'b1;
							sda_out_d    = shift_d[7];
						end else begin
							state_d = cg_regs_pkg::ST_INDEX;
						end
					end
					cg_regs_pkg::ST_INDEX: begin
						index_d = shift_q;
						state_d = cg_regs_pkg::ST_COUNT;
					end
					cg_regs_pkg::ST_COUNT: begin
						count_d = shift_q;
						state_d = cg_regs_pkg::ST_WDATA;
					end
					cg_regs_pkg::ST_WDATA: begin
						if (index_q == cg_regs_pkg::IDX_SPREAD_OUT_BEHAV) begin
							reg1_d = merge_bits(reg1_q, shift_q, cg_regs_pkg::WMASK_SPREAD_OUT);
						end
						if (index_q == cg_regs_pkg::IDX_STOP_PD_DRIVE) begin
							reg2_d = merge_bits(reg2_q, shift_q, cg_regs_pkg::WMASK_STOP_PD);
						end
						index_d = index_q + 8'h01;
						count_d = count_q - 8'h01;
					end
					default: begin
						state_d = cg_regs_pkg::ST_SKIP;
					end
				endcase
			end else if (scl_fall && (bit_q == cg_regs_pkg::BIT_ACK)) begin
				if (byte_ok) begin
					sda_oe_d   = 1'b1;
					sda_out_d  = 1'b0;
					ack_slot_d = 1'b1;
				end else begin
					// foreign address or surplus byte: stay off the line
					state_d = cg_regs_pkg::ST_SKIP;
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q      <= cg_regs_pkg::ST_IDLE;
			bit_q        <= '0;
			ack_slot_q   <= 1'b0;
			host_nack_q  <= 1'b0;
			count_sent_q <= 1'b0;
			shift_q      <= '0;
			index_q      <= '0;
			count_q      <= '0;
			sda_oe_q     <= 1'b0;
			sda_out_q    <= 1'b1;
			reg1_q       <= cg_regs_pkg::RST_SPREAD_OUT_BEHAV;
			reg2_q       <= cg_regs_pkg::RST_STOP_PD_DRIVE;
		end else begin
			state_q      <= state_d;
			bit_q        <= bit_d;
			ack_slot_q   <= ack_slot_d;
			host_nack_q  <= host_nack_d;
			count_sent_q <= count_sent_d;
			shift_q      <= shift_d;
			index_q      <= index_d;
			count_q      <= count_d;
			sda_oe_q     <= sda_oe_d;
			sda_out_q    <= sda_out_d;
			reg1_q       <= reg1_d;
			reg2_q       <= reg2_d;
		end
	end

	// ==========================================================
	// output behaviour decoded from the registers
	cg_regs_pkg::out_ctrl_t out_q, out_d;
	logic                   stop_req_q, stop_req_d;
	logic                   tristate_q, tristate_d;

	always_comb begin
		out_d.host_pair_en = {reg1_q[cg_regs_pkg::BIT_HOST_PAIR2_EN],
			reg1_q[cg_regs_pkg::BIT_HOST_PAIR1_EN], reg1_q[cg_regs_pkg::BIT_HOST_PAIR0_EN]};
		out_d.host_pair_pd_tristate = {reg2_q[cg_regs_pkg::BIT_PAIR2_PD_DRIVE],
			reg2_q[cg_regs_pkg::BIT_PAIR1_PD_DRIVE], reg2_q[cg_regs_pkg::BIT_PAIR0_PD_DRIVE]}
			& {3{pd_active}};
		out_d.serial_ref_en                  = reg1_q[cg_regs_pkg::BIT_SREF_EN];
		out_d.serial_ref_stoppable           = reg1_q[cg_regs_pkg::BIT_SREF_STOPPABLE];
		out_d.serial_ref_stop_drive_sel      = reg2_q[cg_regs_pkg::BIT_SREF_STOP_DRIVE];
		out_d.serial_ref_powerdown_drive_sel = reg2_q[cg_regs_pkg::BIT_SREF_PD_DRIVE];
		// a free-running pair never sees the stop pin
		stop_req_d = stop_active & out_d.serial_ref_stoppable;
		tristate_d = (stop_req_d & out_d.serial_ref_stop_drive_sel)
			| (pd_active & out_d.serial_ref_powerdown_drive_sel);
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_q <= '{
				host_pair_en: cg_regs_pkg::RST_SPREAD_OUT_BEHAV[cg_regs_pkg::BIT_HOST_PAIR2_EN:
					cg_regs_pkg::BIT_HOST_PAIR0_EN],
				host_pair_pd_tristate: 3'h0,
				serial_ref_en: cg_regs_pkg::RST_SPREAD_OUT_BEHAV[cg_regs_pkg::BIT_SREF_EN],
				serial_ref_stoppable:
					cg_regs_pkg::RST_SPREAD_OUT_BEHAV[cg_regs_pkg::BIT_SREF_STOPPABLE],
				serial_ref_stop_drive_sel:
					cg_regs_pkg::RST_STOP_PD_DRIVE[cg_regs_pkg::BIT_SREF_STOP_DRIVE],
				serial_ref_powerdown_drive_sel:
					cg_regs_pkg::RST_STOP_PD_DRIVE[cg_regs_pkg::BIT_SREF_PD_DRIVE]
			};
			stop_req_q <= 1'b0;
			tristate_q <= 1'b0;
		end else begin
			out_q      <= out_d;
			stop_req_q <= stop_req_d;
			tristate_q <= tristate_d;
		end
	end

	assign o_sda_oe                = sda_oe_q;
	assign o_sda_out               = sda_out_q;
	assign o_host_pair_en          = out_q.host_pair_en;
	assign o_host_pair_pd_tristate = out_q.host_pair_pd_tristate;
	assign o_serial_ref_en         = out_q.serial_ref_en;
	assign o_serial_ref_stop_req   = stop_req_q;
	assign o_serial_ref_tristate   = tristate_q;
endmodule

// file: cg_serial_regs_sva.sv
// checks on the serial register port
`timescale 1ns/1ps
module cg_serial_regs_sva (
	input wire logic       i_clk_sys,
	input wire logic       i_rst_n,
	input wire logic       i_scl,
	input wire logic       i_sda,
	input wire logic       i_stop_n,
	input wire logic       i_power_down_n,
	input wire logic       o_sda_oe,
	input wire logic       o_sda_out,
	input wire logic [2:0] o_host_pair_pd_tristate,
	input wire logic       o_serial_ref_stop_req,
	input wire logic       o_serial_ref_tristate
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// a data change under a high clock would read as start or stop
	property p_hold; i_scl && $past(i_scl) |-> $stable({o_sda_oe, o_sda_out}); endproperty
	a_hold: assert property (p_hold) else $error("data moved, clock high");
	property p_tri; (i_stop_n && i_power_down_n)[*8] |-> !o_serial_ref_tristate; endproperty
	a_tri: assert property (p_tri) else $error("tristate while running");
	property p_free_run; i_stop_n[*5] |-> !o_serial_ref_stop_req; endproperty
	a_free_run: assert property (p_free_run) else $error("stop request, pin high");
	property p_pd_drive; i_power_down_n[*5] |-> (o_host_pair_pd_tristate == 3'h0); endproperty
	a_pd_drive: assert property (p_pd_drive) else $error("pair tristate, powered");
	// the port may only take the data line while the clock is low
	property p_drive_low; $rose(o_sda_oe) |-> !i_scl; endproperty
	a_drive_low: assert property (p_drive_low) else $error("drive began, clock high");
	property p_idle; (i_scl && i_sda)[*8] |-> !o_sda_oe; endproperty
	a_idle: assert property (p_idle) else $error("line held on idle bus");
endmodule
bind cg_serial_regs cg_serial_regs_sva u_cg_serial_regs_sva (
	.i_clk_sys               (i_clk_sys),
	.i_rst_n                 (i_rst_n),
	.i_scl                   (i_scl),
	.i_sda                   (i_sda),
	.i_stop_n                (i_stop_n),
	.i_power_down_n          (i_power_down_n),
	.o_sda_oe                (o_sda_oe),
	.o_sda_out               (o_sda_out),
	.o_host_pair_pd_tristate (o_host_pair_pd_tristate),
	.o_serial_ref_stop_req   (o_serial_ref_stop_req),
	.o_serial_ref_tristate   (o_serial_ref_tristate)
);

// file: clock_gen_i2c_block_regs_bench.sv
// bench for the serial register port
`timescale 1ns/1ps
module clock_gen_i2c_block_regs_bench;
	logic i_clk_sys = 0, i_rst_n = 0, i_stop_n = 1, i_power_down_n = 1, hs, k;
	logic o_sda_oe, o_sda_out, o_serial_ref_stop_req, o_serial_ref_tristate;
	logic [2:0] o_host_pair_en, o_host_pair_pd_tristate;
	logic i_freq_sel_low = 0, i_freq_sel_high = 1, o_serial_ref_en;
	logic [7:0] r;
	wire i_scl;
	wire i_sda = hs & !(o_sda_oe & !o_sda_out);
	int n_mismatch = 0, compares = 0;
	initial forever #2.5 i_clk_sys = ~i_clk_sys;
	cg_host_model u_cg_host_model (.o_scl(i_scl), .o_sda(hs), .i_sda(i_sda));
	cg_serial_regs u_cg_serial_regs (
		.i_clk_sys               (i_clk_sys),
		.i_rst_n                 (i_rst_n),
		.i_scl                   (i_scl),
		.i_sda                   (i_sda),
		.o_sda_oe                (o_sda_oe),
		.o_sda_out               (o_sda_out),
		.i_freq_sel_low          (i_freq_sel_low),
		.i_freq_sel_high         (i_freq_sel_high),
		.i_stop_n                (i_stop_n),
		.i_power_down_n          (i_power_down_n),
		.o_host_pair_en          (o_host_pair_en),
		.o_host_pair_pd_tristate (o_host_pair_pd_tristate),
		.o_serial_ref_en         (o_serial_ref_en),
		.o_serial_ref_stop_req   (o_serial_ref_stop_req),
		.o_serial_ref_tristate   (o_serial_ref_tristate)
	);
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wb(logic [7:0] d); u_cg_host_model.xfer(d, 1, r, k); chk("ack", 8'h00, {7'h0, k}); endtask
	task automatic rb(logic a); u_cg_host_model.xfer(8'hFF, a, r, k); endtask
	task automatic wr(logic [7:0] n, int c, logic [15:0] d);
		u_cg_host_model.st();
		wb(cg_regs_pkg::ADDR_WR);
		wb(n);
		wb(8'(c));
		for (int i = 0; i < c; i++) wb(d[8*i+:8]);
		u_cg_host_model.sp();
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#300000 n_mismatch++;
		test_done();
	end
	initial begin
		repeat (10) @(negedge i_clk_sys);
		i_rst_n = 1;
		chk("pair_en", 8'h07, {5'h0, o_host_pair_en});
		chk("sref_en", 8'h01, {7'h0, o_serial_ref_en});
		wr(8'h01, 2, 16'h4000);
		chk("pair_en", 8'h00, {5'h0, o_host_pair_en});
		chk("sref_en", 8'h00, {7'h0, o_serial_ref_en});
		u_cg_host_model.st();
		wb(cg_regs_pkg::ADDR_WR);
		wb(8'h00);
		u_cg_host_model.st();
		wb(cg_regs_pkg::ADDR_RD);
		rb(0);
		chk("count", 8'h03, r);
		rb(0);
		chk("byte0", 8'h02, r & 8'h03);
		rb(0);
		chk("byte1", 8'h00, r & cg_regs_pkg::WMASK_SPREAD_OUT);
		rb(1);
		chk("byte2", 8'h40, r & cg_regs_pkg::WMASK_STOP_PD);
		u_cg_host_model.sp();
		$display("write and read done");
		@(negedge i_clk_sys) i_stop_n = 0;
		#200 chk("free_run", 8'h00, {7'h0, o_serial_ref_stop_req});
		wr(8'h01, 1, 16'h00C0);
		#200 chk("tristate", 8'h01, {7'h0, o_serial_ref_tristate});
		chk("sref_en", 8'h01, {7'h0, o_serial_ref_en});
		wr(8'h02, 1, 16'h0038);
		@(negedge i_clk_sys) i_power_down_n = 0;
		#200 chk("pd_tristate", 8'h07, {5'h0, o_host_pair_pd_tristate});
		chk("sref_pd", 8'h00, {7'h0, o_serial_ref_tristate});
		@(negedge i_clk_sys) i_power_down_n = 1;
		$display("drive mode done");
		u_cg_host_model.st();
		u_cg_host_model.xfer(8'hA0, 1, r, k);
		chk("foreign", 8'h01, {7'h0, k});
		u_cg_host_model.sp();
		$display("stop and address done");
		test_done();
	end
endmodule
